// ===== logic/encoder_index_defs.vh
// Function
// - Config bit 0 selects binary (0) or decimal (1) encoder constant, A/B/N only.
// - Bit 1 clear blocks position reload; set allows reload per continuous or one-shot bits.
// - Bit 2 set clears/latches position on every qualified index event.
// - Bit 3 set clears/latches position on the next qualified index event only.
// - After that single clear/latch the one-shot bit returns to zero automatically.
// - Bit 4 low makes index low-active; high makes it high-active.
// - Bits 6:5 pick level, edge into active, edge into inactive, or both edges.
// - Unless bypassed, bit 7 gives the A level required for a valid event.
// - Unless bypassed, bit 8 gives the B level required for a valid event.
// - Bit 9 set ignores A and B levels for index events.
`ifndef ENCODER_INDEX_DEFS_VH
`define ENCODER_INDEX_DEFS_VH

`define DATA_W 32
`define ADDR_W 8
`define CFG_RESET 32'h00000400

// Register indices; byte address is four times the index
`define IDX_CFG 6'h07
`define IDX_STATUS 6'h08
`define IDX_LATCH 6'h09
`define IDX_COUNT 6'h0A
`define ADDR_LANE 2'h0

// Configuration fields
`define CFG_DECIMAL 0
`define CFG_RELOAD 1
`define CFG_CONT 2
`define CFG_ONCE 3
`define CFG_POL_N 4
`define CFG_MODE_LO 5
`define CFG_MODE_HI 6
`define CFG_POL_A 7
`define CFG_POL_B 8
`define CFG_BYPASS 9

// Trigger modes
`define MODE_LEVEL 2'h0
`define MODE_TO_ACTIVE 2'h1
`define MODE_TO_INACTIVE 2'h2
`define MODE_BOTH 2'h3

// Status fields
`define ST_N 0
`define ST_A 1
`define ST_B 2
`define ST_ACTIVE 3
`define ST_EVENT 4
`define ST_ARMED 5
`define ST_CONFLICT 6
`define ST_W 7

`define COUNT_W 16
`define SYNC_W 3

`endif

// ===== logic/input_sync.v
`timescale 1ns/100ps
`include "encoder_index_defs.vh"
module input_sync (
  clk,
  rstn,
  din,
  dout
);
  input wire clk;
  input wire rstn;
  input wire [`SYNC_W-1:0] din;
  output wire [`SYNC_W-1:0] dout;

  genvar i;
  generate
    for (i = 0; i < `SYNC_W; i = i + 1) begin : g_bit
      reg meta_q;
      reg sync_q;
      always @(posedge clk) begin
        if (!rstn) begin
          meta_q <= 1'h0;
          sync_q <= 1'h0;
        end else begin
          meta_q <= din[i];
          sync_q <= meta_q;
        end
      end
      assign dout[i] = sync_q;
    end
  endgenerate
endmodule

// ===== logic/index_qualify.v
`timescale 1ns/100ps
`include "encoder_index_defs.vh"
module index_qualify (
  clk,
  rstn,
  n_s,
  a_s,
  b_s,
  pol_n,
  mode,
  pol_a,
  pol_b,
  bypass,
  n_active,
  hit
);
  input wire clk;
  input wire rstn;
  input wire n_s;
  input wire a_s;
  input wire b_s;
  input wire pol_n;
  input wire [1:0] mode;
  input wire pol_a;
  input wire pol_b;
  input wire bypass;
  output wire n_active;
  output reg hit;

  reg n_prev_q;
  reg prev_valid_q;
  wire prev_active;
  wire to_active;
  wire to_inactive;
  wire ab_ok;
  reg trig;

  // First sample after reset has no history; no false edge from it
  always @(posedge clk) begin
    if (!rstn) begin
      n_prev_q <= 1'h0;
      prev_valid_q <= 1'h0;
    end else begin
      n_prev_q <= n_s;
      prev_valid_q <= 1'h1;
    end
  end

  assign n_active = (n_s == pol_n);
  assign prev_active = (n_prev_q == pol_n);
  assign to_active = prev_valid_q & n_active & ~prev_active;
  assign to_inactive = prev_valid_q & ~n_active & prev_active;
  assign ab_ok = bypass | ((a_s == pol_a) & (b_s == pol_b));

  always @* begin
    trig = 1'h0;
    case (mode)
      `MODE_LEVEL: trig = n_active;
      `MODE_TO_ACTIVE: trig = to_active;
      `MODE_TO_INACTIVE: trig = to_inactive;
      `MODE_BOTH: trig = to_active | to_inactive;
      default: trig = 1'h0;
    endcase
    hit = trig & ab_ok;
  end
endmodule

// ===== logic/encoder_index_event_config.v
// Strobed register access is this design's own decision.
`timescale 1ns/100ps
`include "encoder_index_defs.vh"
module encoder_index_event_config (
  clk,
  rstn,
  addr,
  wdata,
  wr,
  rd,
  rdata,
  enc_a,
  enc_b,
  enc_n,
  enc_pos,
  closed_loop,
  decimal_mode,
  index_event,
  pos_clear,
  pos_latch,
  latched_pos
);
  input wire clk;
  input wire rstn;
  input wire [`ADDR_W-1:0] addr;
  input wire [`DATA_W-1:0] wdata;
  input wire wr;
  input wire rd;
  output reg [`DATA_W-1:0] rdata;
  input wire enc_a;
  input wire enc_b;
  input wire enc_n;
  input wire [`DATA_W-1:0] enc_pos;
  input wire closed_loop;
  output reg decimal_mode;
  output reg index_event;
  output reg pos_clear;
  output reg pos_latch;
  output reg [`DATA_W-1:0] latched_pos;

  // Configuration and state
  reg [`DATA_W-1:0] cfg_q;
  reg [`DATA_W-1:0] cfg_d;
  reg event_seen_q;
  reg event_seen_d;
  reg conflict_q;
  reg conflict_d;
  reg [`COUNT_W-1:0] count_q;
  reg [`COUNT_W-1:0] count_d;
  reg [`DATA_W-1:0] rdata_d;

  // Address decode
  wire lane_ok;
  wire sel_cfg;
  wire sel_status;
  wire sel_latch;
  wire sel_count;
  wire wr_cfg;
  wire wr_status;
  wire wr_count;

  // Synchronised inputs
  wire [`SYNC_W-1:0] raw_in;
  wire [`SYNC_W-1:0] sync_in;
  wire n_s;
  wire a_s;
  wire b_s;

  // Event path
  wire n_active;
  wire hit;
  wire take;
  wire once_fire;
  wire do_clear;
  wire [`ST_W-1:0] status;

  assign lane_ok = (addr[1:0] == `ADDR_LANE);
  assign sel_cfg = lane_ok & (addr[`ADDR_W-1:2] == `IDX_CFG);
  assign sel_status = lane_ok & (addr[`ADDR_W-1:2] == `IDX_STATUS);
  assign sel_latch = lane_ok & (addr[`ADDR_W-1:2] == `IDX_LATCH);
  assign sel_count = lane_ok & (addr[`ADDR_W-1:2] == `IDX_COUNT);
  assign wr_cfg = wr & sel_cfg;
  assign wr_status = wr & sel_status;
  assign wr_count = wr & sel_count;

  assign raw_in = {enc_b, enc_a, enc_n};

  input_sync u_sync (
    .clk(clk),
    .rstn(rstn),
    .din(raw_in),
    .dout(sync_in)
  );

  assign n_s = sync_in[0];
  assign a_s = sync_in[1];
  assign b_s = sync_in[2];

  index_qualify u_qualify (
    .clk(clk),
    .rstn(rstn),
    .n_s(n_s),
    .a_s(a_s),
    .b_s(b_s),
    .pol_n(cfg_q[`CFG_POL_N]),
    .mode(cfg_q[`CFG_MODE_HI:`CFG_MODE_LO]),
    .pol_a(cfg_q[`CFG_POL_A]),
    .pol_b(cfg_q[`CFG_POL_B]),
    .bypass(cfg_q[`CFG_BYPASS]),
    .n_active(n_active),
    .hit(hit)
  );

  // Either request bit makes the event act on the position
  assign take = hit & (cfg_q[`CFG_CONT] | cfg_q[`CFG_ONCE]);
  assign once_fire = hit & cfg_q[`CFG_ONCE];

  // Reload only when enabled; latch happens regardless
  assign do_clear = take & cfg_q[`CFG_RELOAD];

  assign status = {
    conflict_q,
    cfg_q[`CFG_ONCE],
    event_seen_q,
    n_active,
    b_s,
    a_s,
    n_s
  };

  // Configuration register
  always @* begin
    cfg_d = cfg_q;
    if (once_fire) begin
      cfg_d[`CFG_ONCE] = 1'h0;
    end
    // A fresh write re-arms even if the old one-shot fires now
    if (wr_cfg) begin
      cfg_d = wdata;
    end
  end

  // Sticky event flag, write one to clear, new event wins
  always @* begin
    event_seen_d = event_seen_q;
    if (wr_status & wdata[`ST_EVENT]) begin
      event_seen_d = 1'h0;
    end
    if (hit) begin
      event_seen_d = 1'h1;
    end
  end

  // Reload armed while closed loop runs is flagged for software
  always @* begin
    conflict_d = conflict_q;
    if (wr_status & wdata[`ST_CONFLICT]) begin
      conflict_d = 1'h0;
    end
    if (closed_loop & cfg_q[`CFG_RELOAD]) begin
      conflict_d = 1'h1;
    end
  end

  // Event counter, cleared by a count register write; a same-cycle event leaves it at 1; wraps silently
  always @* begin
    count_d = count_q;
    if (wr_count) begin
      count_d = {`COUNT_W{1'h0}};
    end
    if (hit) begin
      count_d = count_d + {{(`COUNT_W-1){1'h0}}, 1'h1};
    end
  end

  // Read mux; unmapped addresses read zero
  always @* begin
    rdata_d = {`DATA_W{1'h0}};
    if (rd) begin
      if (sel_cfg) begin
        rdata_d = cfg_q;
      end else if (sel_status) begin
        rdata_d = {{(`DATA_W-`ST_W){1'h0}}, status};
      end else if (sel_latch) begin
        rdata_d = latched_pos;
      end else if (sel_count) begin
        rdata_d = {{(`DATA_W-`COUNT_W){1'h0}}, count_q};
      end
    end
  end

  always @(posedge clk) begin
    if (!rstn) begin
      cfg_q <= `CFG_RESET;
      event_seen_q <= 1'h0;
      conflict_q <= 1'h0;
      count_q <= {`COUNT_W{1'h0}};
      rdata <= {`DATA_W{1'h0}};
    end else begin
      cfg_q <= cfg_d;
      event_seen_q <= event_seen_d;
      conflict_q <= conflict_d;
      count_q <= count_d;
      rdata <= rdata_d;
    end
  end

  // Registered outputs to the position counter
  always @(posedge clk) begin
    if (!rstn) begin
      decimal_mode <= 1'h0;
      index_event <= 1'h0;
      pos_clear <= 1'h0;
      pos_latch <= 1'h0;
      latched_pos <= {`DATA_W{1'h0}};
    end else begin
      decimal_mode <= cfg_d[`CFG_DECIMAL];
      index_event <= hit;
      pos_clear <= do_clear;
      pos_latch <= take;
      if (take) begin
        latched_pos <= enc_pos;
      end
    end
  end
endmodule

// ===== sim/index_event_chk_sva.sv
`timescale 1ns/100ps
`include "encoder_index_defs.vh"
module index_event_chk (
  input wire clk,
  input wire rstn,
  input wire [`ADDR_W-1:0] addr,
  input wire [`DATA_W-1:0] wdata,
  input wire wr,
  input wire enc_a,
  input wire enc_b,
  input wire enc_n,
  input wire [`DATA_W-1:0] enc_pos,
  input wire decimal_mode,
  input wire index_event,
  input wire pos_clear,
  input wire pos_latch,
  input wire [`DATA_W-1:0] latched_pos
);
  logic [9:0] cfg_q;
  // Bit 3 unused here: the device clears it on its own
  always @(posedge clk) begin
    if (!rstn) cfg_q <= 10'h000;
    else if (wr && addr == 8'h1C) cfg_q <= wdata[9:0];
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  cfg_echo_a: assert property (wr && addr == 8'h1C |=> decimal_mode == $past(wdata[0]))
    else $error("decimal mode wrong");
  clear_gate_a: assert property (pos_clear |-> pos_latch && $past(cfg_q[1]))
    else $error("clear without reload");
  latch_cause_a: assert property (pos_latch |-> index_event)
    else $error("latch without event");
  latch_value_a: assert property (pos_latch |-> latched_pos == $past(enc_pos))
    else $error("latched value wrong");
  level_pol_a: assert property (index_event && $past(cfg_q[6:5]) == 2'h0 |->
    $past(enc_n, 3) == $past(cfg_q[4]))
    else $error("level event at wrong polarity");
  edge_kind_a: assert property (index_event && $past(cfg_q[6:5]) != 2'h0 |->
    $past(enc_n, 3) != $past(enc_n, 4) && ($past(cfg_q[6:5]) == 2'h3 ||
    ($past(enc_n, 3) == $past(cfg_q[4])) == ($past(cfg_q[6:5]) == 2'h1)))
    else $error("edge event wrong");
  a_gate_a: assert property (index_event && !$past(cfg_q[9]) |->
    $past(enc_a, 3) == $past(cfg_q[7]))
    else $error("A level ignored");
  b_gate_a: assert property (index_event && !$past(cfg_q[9]) |->
    $past(enc_b, 3) == $past(cfg_q[8]))
    else $error("B level ignored");
  cover property (pos_clear);
  cover property (index_event && $past(cfg_q[6:5]) == 2'h3);
  cover property (index_event && !$past(cfg_q[9]));
endmodule
bind encoder_index_event_config index_event_chk u_index_event_chk (.clk, .rstn, .addr, .wdata,
  .wr, .enc_a, .enc_b, .enc_n, .enc_pos, .decimal_mode, .index_event, .pos_clear, .pos_latch,
  .latched_pos);

// ===== sim/quad_encoder_model.sv
`timescale 1ns/100ps
module quad_encoder_model (
  input wire clk,
  output logic a,
  output logic b,
  output logic n
);
  initial {a, b, n} = 3'h0;
  // Levels held long enough for the sync chain and edge compare
  task automatic drive(input logic [2:0] abn);
    @(posedge clk);
    {a, b, n} <= abn;
    repeat (5) @(posedge clk);
  endtask
endmodule

// ===== sim/encoder_index_event_config_tb_top.sv
`timescale 1ns/100ps
`include "encoder_index_defs.vh"
module encoder_index_event_config_tb_top;
  logic clk = 0, rstn = 0, wr = 0, rd = 0;
  logic closed_loop = 0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0, enc_pos = 32'h0;
  wire [31:0] rdata, latched_pos;
  wire enc_a, enc_b, enc_n, decimal_mode, index_event, pos_clear, pos_latch;
  int failures = 0, check_count = 0, ev_n = 0, lt_n = 0, cl_n = 0;
  always #2 clk = ~clk;
  always @(posedge clk) begin
    enc_pos <= enc_pos + 32'h1;
    ev_n <= ev_n + index_event;
    lt_n <= lt_n + pos_latch;
    cl_n <= cl_n + pos_clear;
  end
  encoder_index_event_config u_encoder_index_event_config (.clk, .rstn, .addr, .wdata, .wr,
    .rd, .rdata, .enc_a, .enc_b, .enc_n, .enc_pos, .closed_loop, .decimal_mode, .index_event,
    .pos_clear, .pos_latch, .latched_pos);
  quad_encoder_model u_quad_encoder_model (.clk, .a(enc_a), .b(enc_b), .n(enc_n));
  task automatic check(input logic [31:0] got, exp, input string what);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("FAIL %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 check(rdata, exp, "read");
  endtask
  task automatic run(input logic [31:0] cfg, input logic [2:0] pre, post, input int ev, lt, cl);
    int e0, l0, c0;
    wr_reg(8'h1C, cfg);
    u_quad_encoder_model.drive(pre);
    e0 = ev_n;
    l0 = lt_n;
    c0 = cl_n;
    u_quad_encoder_model.drive(post);
    u_quad_encoder_model.drive(pre);
    check(32'(ev_n - e0), 32'(ev), "events");
    check(32'(lt_n - l0), 32'(lt), "latches");
    check(32'(cl_n - c0), 32'(cl), "clears");
    $display("test done cfg %h", cfg);
  endtask
  task automatic close_out;
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    rd_chk(8'h1C, 32'h400);
    rd_chk(8'h40, 32'h0);
    wr_reg(8'h1C, 32'h401);
    #1 check({31'h0, decimal_mode}, 32'h1, "decimal");
    $display("test done registers");
    run(32'h204, 3'h1, 3'h0, 6, 6, 0);
    run(32'h23A, 3'h0, 3'h1, 1, 1, 1);
    rd_chk(8'h1C, 32'h232);
    run(32'h232, 3'h0, 3'h1, 1, 0, 0);
    run(32'h254, 3'h0, 3'h1, 1, 1, 0);
    run(32'h270, 3'h0, 3'h1, 2, 0, 0);
    run(32'h0B4, 3'h4, 3'h5, 1, 1, 0);
    run(32'h0B4, 3'h6, 3'h7, 0, 0, 0);
    run(32'h0B4, 3'h0, 3'h1, 0, 0, 0);
    run(32'h2B4, 3'h0, 3'h1, 1, 1, 0);
    wr_reg(8'h28, 32'h0);
    rd_chk(8'h28, 32'h0);
    closed_loop <= 1'b1;
    wr_reg(8'h1C, 32'h212);
    rd_chk(8'h20, 32'h50);
    closed_loop <= 1'b0;
    wr_reg(8'h20, 32'h50);
    rd_chk(8'h20, 32'h0);
    $display("test done status");
    close_out;
  end
  initial begin
    repeat (3000) @(posedge clk);
    failures++;
    close_out;
  end
endmodule
